// file: logic/msp_defs.svh
// offsets, field positions, reset values and timing counts of the select block
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// register offsets within the configuration register space
`define MSP_OFF_PAGE        8'hF0
`define MSP_OFF_SPACE_MAP   8'hF1
`define MSP_OFF_PWR_A       8'hF2
`define MSP_OFF_PWR_C       8'hF3

// space-mapping register fields
`define MSP_SM_PERIPH_IO_ENABLE       7
`define MSP_SM_FLASH_IN_DATA_SPACE      4
`define MSP_SM_EEPROM_IN_DATA_SPACE      3
`define MSP_SM_FLASH_IN_CODE_SPACE      2
`define MSP_SM_EEPROM_IN_CODE_SPACE      1
`define MSP_SM_SRAM_CODE    0
`define MSP_SM_USED_MASK    8'h9F

// power mode register fields
`define MSP_PWR_A_TURBO     3

// reset values
`define MSP_RST_PAGE        8'h00
`define MSP_RST_SPACE_MAP   8'h0C
`define MSP_RST_PWR_A       8'h08
`define MSP_RST_PWR_C       8'h00

// standby idle time and clock
`define MSP_STANDBY_NS      70
`define MSP_CLK_NS          20
`define MSP_STANDBY_CYC     ((`MSP_STANDBY_NS + `MSP_CLK_NS - 1) / `MSP_CLK_NS)

`endif

// file: logic/msp_pkg.sv
// types shared by the select block
package msp_pkg;

	typedef enum logic [1:0]
	{
		MSP_WIN_NONE   = 2'b00,
		MSP_WIN_SECTOR = 2'b01,
		MSP_WIN_EEPROM = 2'b11,
		MSP_WIN_SPACE  = 2'b10
	} msp_winner_e;

	typedef enum logic [1:0]
	{
		MSP_PWR_ACTIVE  = 2'b00,
		MSP_PWR_IDLE    = 2'b01,
		MSP_PWR_STANDBY = 2'b11
	} msp_pwr_e;

endpackage

// file: logic/msp_standby.sv
// idle counter that drops the logic arrays into standby
`timescale 1ns/100ps

module msp_standby #(
	parameter int IDLE_CYC = 4
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic turbo_on,
	input  wire logic inputs_changed,
	output logic      standby
);

	typedef struct packed
	{
		msp_pkg::msp_pwr_e state;
		logic [7:0]        count;
	} msp_sb_s;

	msp_sb_s cur;
	msp_sb_s next_cur;

	// ==========================================================
	// next state
	always_comb
	begin
		next_cur = cur;
		case (cur.state)
			msp_pkg::MSP_PWR_ACTIVE:
			begin
				next_cur.count = 8'h00;
				if (!turbo_on && !inputs_changed)
					next_cur.state = msp_pkg::MSP_PWR_IDLE;
			end
			msp_pkg::MSP_PWR_IDLE:
			begin
				if (turbo_on || inputs_changed)
					next_cur.state = msp_pkg::MSP_PWR_ACTIVE;
				else if (cur.count >= 8'(IDLE_CYC - 1))
					next_cur.state = msp_pkg::MSP_PWR_STANDBY;
				else
					next_cur.count = cur.count + 8'h01;
			end
			msp_pkg::MSP_PWR_STANDBY:
			begin
				if (turbo_on || inputs_changed)
					next_cur.state = msp_pkg::MSP_PWR_ACTIVE;
			end
			default:
				next_cur.state = msp_pkg::MSP_PWR_ACTIVE;
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur.state <= msp_pkg::MSP_PWR_ACTIVE;
			cur.count <= 8'h00;
		end
		else
			cur <= next_cur;
	end

	assign standby = (cur.state == msp_pkg::MSP_PWR_STANDBY);

endmodule

// file: logic/msp_select.sv
// memory select priority, space mapping and page register of the decode logic
`timescale 1ns/100ps
`include "msp_defs.svh"

module msp_select #(
	parameter int                 FLASH_SECTORS = 8,
	parameter int                 EE_SECTORS    = 4,
	parameter logic [7:0]         SPACE_MAP_INIT = `MSP_RST_SPACE_MAP,
	parameter int                 STANDBY_CYC   = `MSP_STANDBY_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// decode equation results
	input  wire logic [FLASH_SECTORS-1:0] flash_sector_eq,
	input  wire logic [EE_SECTORS-1:0]    eeprom_sector_eq,
	input  wire logic                     sram_eq,
	input  wire logic                     io_eq,
	input  wire logic                     periph_io_eq,
	input  wire logic                     config_reg_space,
	// microcontroller bus
	input  wire logic [19:0]              mcu_addr,
	input  wire logic                     wide_addr_mode,
	input  wire logic                     code_fetch_strobe_n,
	input  wire logic                     read_strobe_n,
	input  wire logic                     write_strobe_n,
	input  wire logic [7:0]               data_in,
	output logic      [7:0]               data_out,
	output logic                          data_oe,
	// logic array inputs
	input  wire logic [2:0]               bus_control_inputs,
	input  wire logic                     array_reset,
	input  wire logic                     power_down_input,
	input  wire logic [23:0]              input_cell,
	input  wire logic [2:0]               port_d_inputs,
	input  wire logic [7:0]               output_cell_group1_feedback,
	input  wire logic [7:0]               output_cell_group2_feedback,
	input  wire logic                     eeprom_ready,
	output logic      [72:0]              array_input_bus,
	// selects to memories
	output logic      [FLASH_SECTORS-1:0] flash_sector_select,
	output logic      [EE_SECTORS-1:0]    eeprom_sector_select,
	output logic                          sram_select,
	output logic                          io_select,
	output logic                          periph_io_select,
	output logic                          internal_access,
	output logic      [7:0]               page_bits,
	output logic                          periph_io_enable,
	output logic                          arrays_standby
);

	typedef struct packed
	{
		logic [7:0]                page;
		logic [7:0]                space_map;
		logic [7:0]                pwr_a;
		logic [7:0]                pwr_c;
		logic [7:0]                rd_data;
		logic                      rd_oe;
		logic [FLASH_SECTORS-1:0]  fl_sel;
		logic [EE_SECTORS-1:0]     ee_sel;
		logic                      sram_sel;
		logic                      io_sel;
		logic                      pio_sel;
		logic [72:0]               bus_q;
		logic                      wr_prev;
	} msp_state_s;

	msp_state_s cur;
	msp_state_s next_cur;

	// ==========================================================
	// pin synchronisers
	logic [2:0] sync1_strb;
	logic [2:0] sync2_strb;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_strb <= 3'h7;
			sync2_strb <= 3'h7;
		end
		else
		begin
			sync1_strb <= {write_strobe_n, read_strobe_n, code_fetch_strobe_n};
			sync2_strb <= sync1_strb;
		end
	end

	logic fetch_act;
	logic read_act;
	logic write_act;
	assign fetch_act = ~sync2_strb[0];
	assign read_act  = ~sync2_strb[1];
	assign write_act = ~sync2_strb[2];

	// ==========================================================
	// priority resolution
	logic                     sect_hit;
	logic                     ee_hit;
	logic                     space_hit;
	msp_pkg::msp_winner_e     winner;
	logic                     fl_gate;
	logic                     ee_gate;
	logic                     sr_gate;
	logic [15:0]              addr_in;
	logic [2:0]               ctl_in;
	logic [72:0]              bus_now;
	logic                     reg_hit;
	logic [7:0]               reg_rd;

	always_comb
	begin
		ee_hit    = |eeprom_sector_eq;
		sect_hit  = |flash_sector_eq;
		space_hit = sram_eq | io_eq | (periph_io_eq & cur.space_map[`MSP_SM_PERIPH_IO_ENABLE]);
		// level one: SRAM, I/O, peripheral I/O; two: EEPROM; three: flash
		if (space_hit)
			winner = msp_pkg::MSP_WIN_SPACE;
		else if (ee_hit)
			winner = msp_pkg::MSP_WIN_EEPROM;
		else if (sect_hit)
			winner = msp_pkg::MSP_WIN_SECTOR;
		else
			winner = msp_pkg::MSP_WIN_NONE;
		// strobe gating per memory
		fl_gate = (fetch_act & cur.space_map[`MSP_SM_FLASH_IN_CODE_SPACE])
			| (read_act & cur.space_map[`MSP_SM_FLASH_IN_DATA_SPACE])
			| write_act;
		ee_gate = (fetch_act & cur.space_map[`MSP_SM_EEPROM_IN_CODE_SPACE])
			| (read_act & cur.space_map[`MSP_SM_EEPROM_IN_DATA_SPACE])
			| write_act;
		sr_gate = (fetch_act & cur.space_map[`MSP_SM_SRAM_CODE]) | read_act | write_act;
		// address inputs switch in wide-address mode
		addr_in = wide_addr_mode ? mcu_addr[19:4] : mcu_addr[15:0];
		// five power bits block control signals (three controls, reset, power-down)
		ctl_in  = bus_control_inputs & ~cur.pwr_c[2:0];
		bus_now = {addr_in, ctl_in,
			array_reset & ~cur.pwr_c[3],
			power_down_input & ~cur.pwr_c[4],
			input_cell, port_d_inputs, cur.page,
			output_cell_group1_feedback, output_cell_group2_feedback,
			eeprom_ready};
		// configuration register decode
		reg_hit = 1'b1;
		case (mcu_addr[7:0])
			`MSP_OFF_PAGE:      reg_rd = cur.page;
			`MSP_OFF_SPACE_MAP: reg_rd = cur.space_map & `MSP_SM_USED_MASK;
			`MSP_OFF_PWR_A:     reg_rd = cur.pwr_a;
			`MSP_OFF_PWR_C:     reg_rd = cur.pwr_c;
			default:
			begin
				reg_rd  = 8'h00;
				reg_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb
	begin
		next_cur         = cur;
		next_cur.wr_prev = write_act;
		next_cur.bus_q   = bus_now;
		// sector selects with overlap suppression
		next_cur.fl_sel   = (winner == msp_pkg::MSP_WIN_SECTOR && fl_gate)
			? flash_sector_eq : '0;
		next_cur.ee_sel   = (winner == msp_pkg::MSP_WIN_EEPROM && ee_gate)
			? eeprom_sector_eq : '0;
		next_cur.sram_sel = (winner == msp_pkg::MSP_WIN_SPACE) & sram_eq & sr_gate;
		next_cur.io_sel   = (winner == msp_pkg::MSP_WIN_SPACE) & io_eq & (read_act | write_act);
		next_cur.pio_sel  = (winner == msp_pkg::MSP_WIN_SPACE) & periph_io_eq
			& cur.space_map[`MSP_SM_PERIPH_IO_ENABLE] & (read_act | write_act);
		// register writes on the strobe's leading edge
		if (config_reg_space && write_act && !cur.wr_prev)
		begin
			case (mcu_addr[7:0])
				`MSP_OFF_PAGE:      next_cur.page      = data_in;
				`MSP_OFF_SPACE_MAP: next_cur.space_map = data_in & `MSP_SM_USED_MASK;
				`MSP_OFF_PWR_A:     next_cur.pwr_a     = data_in;
				`MSP_OFF_PWR_C:     next_cur.pwr_c     = data_in & 8'h1F;
				default:            next_cur.page      = cur.page;
			endcase
		end
		// register read drive; nothing else answers unselected
		next_cur.rd_oe   = config_reg_space & reg_hit & read_act;
		next_cur.rd_data = reg_rd;
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur.page      <= `MSP_RST_PAGE;
			cur.space_map <= SPACE_MAP_INIT & `MSP_SM_USED_MASK;
			cur.pwr_a     <= `MSP_RST_PWR_A;
			cur.pwr_c     <= `MSP_RST_PWR_C;
			cur.rd_data   <= 8'h00;
			cur.rd_oe     <= 1'b0;
			cur.fl_sel    <= '0;
			cur.ee_sel    <= '0;
			cur.sram_sel  <= 1'b0;
			cur.io_sel    <= 1'b0;
			cur.pio_sel   <= 1'b0;
			cur.bus_q     <= '0;
			cur.wr_prev   <= 1'b0;
		end
		else
			cur <= next_cur;
	end

	// ==========================================================
	// standby control
	logic inputs_changed;
	assign inputs_changed = (bus_now != cur.bus_q);

	msp_standby #(
		.IDLE_CYC (STANDBY_CYC)
	) u_standby (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.turbo_on       (cur.pwr_a[`MSP_PWR_A_TURBO]),
		.inputs_changed (inputs_changed),
		.standby        (arrays_standby)
	);

	// ==========================================================
	// outputs
	assign flash_sector_select  = cur.fl_sel;
	assign eeprom_sector_select = cur.ee_sel;
	assign sram_select          = cur.sram_sel;
	assign io_select            = cur.io_sel;
	assign periph_io_select     = cur.pio_sel;
	assign internal_access      = (|cur.fl_sel) | (|cur.ee_sel) | cur.sram_sel | cur.io_sel
		| cur.pio_sel | cur.rd_oe;
	assign page_bits            = cur.page;
	assign periph_io_enable     = cur.space_map[`MSP_SM_PERIPH_IO_ENABLE];
	assign data_out             = cur.rd_data;
	assign data_oe              = cur.rd_oe;
	assign array_input_bus      = cur.bus_q;

endmodule

// file: sim/msp_select_assertions.sv
// checker of select priority, strobe timing and register updates
`timescale 1ns/100ps
module msp_select_assertions #(
	parameter int FLASH_SECTORS = 8,
	parameter int EE_SECTORS    = 4
) (
	input wire logic                     clk,
	input wire logic                     sys_rst,
	input wire logic [FLASH_SECTORS-1:0] flash_sector_eq,
	input wire logic                     sram_eq,
	input wire logic                     code_fetch_strobe_n,
	input wire logic                     read_strobe_n,
	input wire logic                     write_strobe_n,
	input wire logic                     data_oe,
	input wire logic [FLASH_SECTORS-1:0] flash_sector_select,
	input wire logic [EE_SECTORS-1:0]    eeprom_sector_select,
	input wire logic                     sram_select,
	input wire logic                     io_select,
	input wire logic                     periph_io_select,
	input wire logic                     internal_access,
	input wire logic [7:0]               page_bits,
	input wire logic                     periph_io_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_eeprom_over_flash: assert property (|eeprom_sector_select |-> flash_sector_select == '0)
		else $error("flash select beside eeprom select");
	a_space_over_sector: assert property ((sram_select || io_select || periph_io_select) |->
		(flash_sector_select == '0) && (eeprom_sector_select == '0)) else $error("sector select beside space select");
	a_sram_eq_cause: assert property (sram_select |-> $past(sram_eq))
		else $error("sram select without its equation");
	a_flash_eq_cause: assert property ((flash_sector_select & ~$past(flash_sector_eq)) == '0)
		else $error("flash select without its equation");
	a_idle_no_select: assert property ((code_fetch_strobe_n && read_strobe_n && write_strobe_n) [*3]
		|=> !internal_access) else $error("internal access with strobes idle");
	a_read_oe_delay: assert property (data_oe |-> !$past(read_strobe_n, 3))
		else $error("data drive without read strobe");
	a_page_write_only: assert property ($changed(page_bits) |-> !$past(write_strobe_n, 2) ||
		!$past(write_strobe_n, 3) || !$past(write_strobe_n, 4)) else $error("page changed without write");
	a_map_write_only: assert property ($changed(periph_io_enable) |-> !$past(write_strobe_n, 2) ||
		!$past(write_strobe_n, 3) || !$past(write_strobe_n, 4)) else $error("map changed without write");
	a_periph_needs_pio: assert property (periph_io_select |-> periph_io_enable || $past(periph_io_enable))
		else $error("periph select with mode off");
	c_eeprom: cover property (|eeprom_sector_select);
	c_sram: cover property (sram_select);
	c_read: cover property (data_oe);
endmodule
bind msp_select msp_select_assertions #(.FLASH_SECTORS(FLASH_SECTORS), .EE_SECTORS(EE_SECTORS))
	msp_select_assertions_i (.clk, .sys_rst, .flash_sector_eq, .sram_eq, .code_fetch_strobe_n, .read_strobe_n,
	.write_strobe_n, .data_oe, .flash_sector_select, .eeprom_sector_select, .sram_select, .io_select,
	.periph_io_select, .internal_access, .page_bits, .periph_io_enable);

// file: sim/msp_mcu_model.sv
// microcontroller bus model driving strobes, address and write data
`timescale 1ns/100ps
module msp_mcu_model (
	input  wire logic        clk,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	output logic      [19:0] mcu_addr,
	output logic             code_fetch_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic      [7:0]  data_in
);
	initial
	begin
		mcu_addr = 20'h00000;
		code_fetch_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		data_in = 8'h00;
	end
	// kind 0 fetch, 1 read, 2 write; three idle edges keep strobes apart
	task automatic access(input logic [1:0] kind, input logic [19:0] a, input logic [7:0] d);
		repeat (3) @(posedge clk);
		#1;
		mcu_addr = a;
		data_in = d;
		code_fetch_strobe_n = (kind != 2'h0);
		read_strobe_n = (kind != 2'h1);
		write_strobe_n = (kind != 2'h2);
		repeat (3) @(posedge clk);
		#1;
		code_fetch_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		// released data line must not keep the last byte
		data_in = ~d;
	endtask
endmodule

// file: sim/tb_msp_select.sv
// testbench of the memory select block
`timescale 1ns/100ps
`include "msp_defs.svh"
module tb_msp_select;
	logic clk = 1'b0, sys_rst = 1'b1, sram_eq = 1'b0, io_eq = 1'b0, periph_io_eq = 1'b0;
	logic config_reg_space = 1'b0, wide_addr_mode = 1'b0, eeprom_ready = 1'b1;
	logic [7:0]  flash_sector_eq = 8'h00;
	logic [3:0]  eeprom_sector_eq = 4'h0;
	logic [2:0]  bus_control_inputs = 3'h0;
	logic [23:0] input_cell = 24'h000000;
	logic [19:0] mcu_addr;
	logic [7:0]  data_in, data_out, page_bits, flash_sector_select;
	logic [3:0]  eeprom_sector_select;
	logic [72:0] array_input_bus;
	logic code_fetch_strobe_n, read_strobe_n, write_strobe_n, data_oe, sram_select, io_select;
	logic periph_io_select, internal_access, periph_io_enable, arrays_standby;
	int err_total = 0, tests_run = 0, cyc = 0;
	// eq and expected select: flash 14:7, eeprom 6:3, sram, io, periph
	localparam logic [14:0] PRI_IN [6] = '{15'h0080, 15'h0088, 15'h008C, 15'h0102, 15'h0011, 15'h0000};
	localparam logic [14:0] PRI_EX [6] = '{15'h0080, 15'h0008, 15'h0004, 15'h0002, 15'h0001, 15'h0000};
	localparam logic [7:0]  MAPS [4] = '{8'h0C, 8'h14, 8'h03, 8'h80};
	msp_select msp_select_i (.clk, .sys_rst, .flash_sector_eq, .eeprom_sector_eq, .sram_eq, .io_eq,
		.periph_io_eq, .config_reg_space, .mcu_addr, .wide_addr_mode, .code_fetch_strobe_n, .read_strobe_n,
		.write_strobe_n, .data_in, .data_out, .data_oe, .bus_control_inputs, .array_reset(1'b0),
		.power_down_input(1'b0), .input_cell, .port_d_inputs(3'h0), .output_cell_group1_feedback(8'h00),
		.output_cell_group2_feedback(8'h00), .eeprom_ready, .array_input_bus, .flash_sector_select,
		.eeprom_sector_select, .sram_select, .io_select, .periph_io_select, .internal_access, .page_bits,
		.periph_io_enable, .arrays_standby);
	msp_mcu_model msp_mcu_model_i (.clk, .data_out, .data_oe, .mcu_addr, .code_fetch_strobe_n, .read_strobe_n,
		.write_strobe_n, .data_in);
	always #10 clk = ~clk;
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [72:0] seen, input logic [72:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
		config_reg_space = 1'b1;
		msp_mcu_model_i.access(2'h2, {12'h000, off}, d);
	endtask
	task automatic reg_rd(input logic [7:0] off, input logic [7:0] exp, input logic oe);
		config_reg_space = 1'b1;
		msp_mcu_model_i.access(2'h1, {12'h000, off}, 8'h00);
		chk("read drive", data_oe, oe);
		if (oe)
			chk("read data", data_out, exp);
	endtask
	task automatic mem(input logic [1:0] kind, input logic [14:0] eq, input logic [14:0] ex);
		{flash_sector_eq, eeprom_sector_eq, sram_eq, io_eq, periph_io_eq} = eq;
		config_reg_space = 1'b0;
		msp_mcu_model_i.access(kind, 20'h08000, 8'h00);
		chk("selects", {flash_sector_select, eeprom_sector_select, sram_select, io_select, periph_io_select}, ex);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		chk("page", page_bits, `MSP_RST_PAGE);
		chk("pio", periph_io_enable, 1'b0);
		reg_rd(`MSP_OFF_SPACE_MAP, `MSP_RST_SPACE_MAP, 1'b1);
	endtask
	task automatic t_page;
		reg_wr(`MSP_OFF_PAGE, 8'hA5);
		reg_rd(`MSP_OFF_PAGE, 8'hA5, 1'b1);
		chk("bus page", array_input_bus[24:17], 8'hA5);
		reg_wr(8'hE0, 8'h3C);
		reg_rd(8'hE0, 8'h00, 1'b0);
		chk("page", page_bits, 8'hA5);
		reg_wr(`MSP_OFF_SPACE_MAP, 8'hFF);
		reg_rd(`MSP_OFF_SPACE_MAP, 8'h9F, 1'b1);
		chk("pio", periph_io_enable, 1'b1);
	endtask
	task automatic t_priority;
		for (int i = 0; i < 6; i++)
			mem(2'h1, PRI_IN[i], PRI_EX[i]);
		chk("no select", internal_access, 1'b0);
	endtask
	task automatic t_space;
		logic [7:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = MAPS[i];
			reg_wr(`MSP_OFF_SPACE_MAP, m);
			for (logic [1:0] k = 2'h0; k < 2'h2; k++)
			begin
				mem(k, 15'h0080, {7'h00, (k == 2'h0) ? m[2] : m[4], 7'h00});
				mem(k, 15'h0008, {11'h000, (k == 2'h0) ? m[1] : m[3], 3'h0});
				mem(k, 15'h0004, {12'h000, (k == 2'h0) ? m[0] : 1'b1, 2'h0});
				mem(k, 15'h0001, {14'h0000, (k == 2'h1) & m[7]});
			end
		end
	endtask
	task automatic t_wide;
		input_cell = 24'h5A5A5A;
		config_reg_space = 1'b0;
		msp_mcu_model_i.access(2'h0, 20'hABCDE, 8'h00);
		tick(2);
		chk("addr", array_input_bus[72:57], 16'hBCDE);
		chk("cells", array_input_bus[51:28], 24'h5A5A5A);
		chk("ready", array_input_bus[0], 1'b1);
		wide_addr_mode = 1'b1;
		tick(2);
		chk("wide addr", array_input_bus[72:57], 16'hABCD);
		wide_addr_mode = 1'b0;
	endtask
	task automatic t_power;
		reg_wr(`MSP_OFF_PWR_C, 8'h07);
		bus_control_inputs = 3'h5;
		tick(3);
		chk("ctl blocked", array_input_bus[56:54], 3'h0);
		reg_wr(`MSP_OFF_PWR_C, 8'h00);
		tick(3);
		chk("ctl", array_input_bus[56:54], 3'h5);
		reg_wr(`MSP_OFF_PWR_A, 8'h00);
		tick(10);
		chk("standby", arrays_standby, 1'b1);
		input_cell = 24'h00FF00;
		tick(3);
		chk("wake", arrays_standby, 1'b0);
		reg_wr(`MSP_OFF_PWR_A, 8'h08);
		tick(10);
		chk("turbo", arrays_standby, 1'b0);
	endtask
	task automatic t_reset2;
		sys_rst = 1'b1;
		tick(3);
		sys_rst = 1'b0;
		tick(1);
		chk("page", page_bits, `MSP_RST_PAGE);
		chk("pio", periph_io_enable, 1'b0);
	endtask
	// ==========================================
	// main sequence and timeout
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			close_out;
		end
	end
	initial
	begin
		tick(10);
		sys_rst = 1'b0;
		tick(1);
		t_reset;
		t_page;
		t_priority;
		t_space;
		t_wide;
		t_power;
		t_reset2;
		close_out;
	end
endmodule
